/* File: tb/host_spi_slave_framing_tb.sv */
// self-checking bench for the host serial slave
`timescale 1ns/1ps
`default_nettype none
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin err_total++; \
   $display("FAIL t=%0t value mismatch", $time); end end
module host_spi_slave_framing_tb
   import hspi_pkg::*;
;
   logic        clk = 1'b0, resetn = 1'b0, two_wire = 1'b0, rx_ready = 1'b1;
   logic        tx_valid = 1'b1;
   logic        sclk, csn, sdi, sdo_q, oe, rx_valid, tx_ready, f_end, f_err, ovr, busy;
   hspi_frame_t mode = HSPI_FRAME_WORD;
   hspi_word_t  rxw;
   hspi_word_t  rxq[$];
   logic [15:0] tx_data = 16'h0000;
   wire         sdo_w = oe ? sdo_q : 1'bz;
   int          err_total = 0, check_count = 0, n_end = 0, n_err = 0, n_ovr = 0;
   int          cyc = 0, seed = 48, n_txr = 0, n_oe = 0;

   hspi_slave dut (.clk(clk), .resetn(resetn), .two_wire_mode(two_wire),
      .frame_mode(mode), .host_serial_clk(sclk), .host_chip_select_n(csn),
      .host_serial_in(sdi), .host_serial_out(sdo_q), .host_serial_out_oe(oe),
      .rx_valid(rx_valid), .rx_ready(rx_ready), .rx_word(rxw), .tx_valid(tx_valid),
      .tx_ready(tx_ready), .tx_data(tx_data), .frame_end(f_end), .frame_error(f_err),
      .rx_overrun(ovr), .busy(busy));
   hspi_host_model host (.clk(clk), .sclk(sclk), .csn(csn), .sdi(sdi), .sdo(sdo_w));

   initial forever #50 clk = ~clk;

   // ----------------------------------------------------------
   // monitor: pulse counts, popped words, hang limit
   // ----------------------------------------------------------
   always @(posedge clk) begin
      cyc++;
      if (f_end === 1'b1) n_end++;
      if (f_err === 1'b1) n_err++;
      if (ovr === 1'b1) n_ovr++;
      if (tx_ready === 1'b1) n_txr++;
      if (oe === 1'b1) n_oe++;
      if (rx_valid === 1'b1 && rx_ready === 1'b1) rxq.push_back(rxw);
      if (cyc == 40000) begin
         err_total++;
         complete_run();
      end
   end

   function automatic hspi_word_t exp_w(logic f, logic [15:0] d, hspi_frame_t m);
      return {f, (m == HSPI_FRAME_BYTE) ? {8'h00, d[7:0]} : d};
   endfunction

   // one frame of whole units plus extra stray bits, then compare all
   task automatic chk_frame(input hspi_frame_t m, input int units, input int extra);
      int b, e0, f0, sh, t0;
      logic [31:0] d, r;
      logic [15:0] mask;
      b = (m == HSPI_FRAME_BYTE) ? 8 : 16;
      mask = (m == HSPI_FRAME_BYTE) ? 16'h00ff : 16'hffff;
      d = $random(seed);
      @(posedge clk);
      mode <= m;
      tx_data <= $random(seed);
      tx_valid <= 1'($random(seed));
      rxq.delete();
      e0 = n_end;
      f0 = n_err;
      t0 = n_txr;
      host.frame(d, units * b + extra, r);
      repeat (4) @(posedge clk);
      `CHK(n_end - e0, 1)
      `CHK(busy, 1'b0)
      `CHK(n_txr - t0, units + ((extra != 0) ? 1 : 0))
      `CHK(n_err - f0, (extra != 0) ? 1 : 0)
      `CHK(rxq.size(), units)
      for (int u = 0; u < units && u < rxq.size(); u++) begin
         sh = (units - 1 - u) * b + extra;
         `CHK(rxq[u], exp_w(u == 0, 16'(d >> sh), m))
         `CHK(16'(r >> sh) & mask, ((tx_valid === 1'b1) ? tx_data : 16'h0000) & mask)
      end
      $display("test done: mode %0d units %0d extra %0d", m, units, extra);
   endtask

   task automatic complete_run();
      $display("checks %0d mismatches %0d", check_count, err_total);
      if (err_total == 0 && check_count > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask

   // ----------------------------------------------------------
   // main sequence
   // ----------------------------------------------------------
   initial begin
      logic [31:0] r;
      int o0;
      repeat (10) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      chk_frame(HSPI_FRAME_WORD, 1, 0);
      chk_frame(HSPI_FRAME_WORD, 2, 0);
      chk_frame(HSPI_FRAME_BYTE, 3, 0);
      chk_frame(HSPI_FRAME_CMD, 2, 0);
      chk_frame(HSPI_FRAME_WORD, 1, 5);
      chk_frame(HSPI_FRAME_BYTE, 1, 3);
      for (int k = 0; k < 6; k++)
         chk_frame(hspi_frame_t'(k % 3), 1 + ($random(seed) & 1), 0);
      host.half = 40;  // long clock halts in both levels
      chk_frame(HSPI_FRAME_WORD, 1, 0);
      host.half = 5;
      // pins belong to the two-wire slave: nothing taken, nothing driven
      two_wire <= 1'b1;
      rxq.delete();
      o0 = n_oe;
      host.frame(32'h0000a5c3, 16, r);
      `CHK(rxq.size(), 0)
      `CHK(n_oe - o0, 0)
      two_wire <= 1'b0;
      repeat (4) @(posedge clk);
      $display("test done: two-wire mode");
      // stalled consumer: fill past 32, then drain to empty
      rx_ready <= 1'b0;
      mode <= HSPI_FRAME_WORD;
      rxq.delete();
      o0 = n_ovr;
      for (int k = 0; k <= HSPI_FIFO_DEPTH; k++)
         host.frame($random(seed), 16, r);
      `CHK(n_ovr - o0, 1)
      `CHK(rx_valid, 1'b1)
      rx_ready <= 1'b1;
      repeat (HSPI_FIFO_DEPTH + 8) @(posedge clk);
      `CHK(rxq.size(), HSPI_FIFO_DEPTH)
      `CHK(rx_valid, 1'b0)
      $display("test done: fifo fill and drain");
      // second reset in mid-run, then traffic again
      resetn <= 1'b0;
      repeat (3) @(posedge clk);
      resetn <= 1'b1;
      repeat (2) @(posedge clk);
      chk_frame(HSPI_FRAME_CMD, 2, 0);
      complete_run();
   end
endmodule
`default_nettype wire

/* File: tb/hspi_host_model.sv */
// host master model driving the slave pins
`timescale 1ns/1ps
`default_nettype none
module hspi_host_model (
   input  wire logic clk,
   output var  logic sclk,
   output var  logic csn,
   output var  logic sdi,
   input  wire logic sdo
);
   int half = 5;  // system clocks per host clock level
   initial begin
      sclk = 1'b1;
      csn  = 1'b1;
      sdi  = 1'b0;
   end
   // idle data line toggles, so a stale level never reads as data
   always @(posedge clk) if (csn) sdi <= ~sdi;

   // send n bits of d msb first, capture the slave output per bit
   task automatic frame(input logic [31:0] d, input int n, output logic [31:0] r);
      r = '0;
      @(posedge clk) csn <= 1'b0;
      repeat (half) @(posedge clk);  // output valid before first rise
      for (int i = n - 1; i >= 0; i--) begin
         sclk <= 1'b0;
         sdi  <= d[i];
         repeat (half) @(posedge clk);
         r[i] = sdo;  // captured just before the rise
         sclk <= 1'b1;
         repeat (half) @(posedge clk);
      end
      csn <= 1'b1;  // low held over every unit
      repeat (half + 2) @(posedge clk);  // off time far above 61 ns
   endtask
endmodule
`default_nettype wire

/* File: tb/hspi_slave_properties.sv */
// port checks for the host serial slave
`timescale 1ns/1ps
`default_nettype none
module hspi_slave_checker
   import hspi_pkg::*;
(
   input wire logic       clk,
   input wire logic       resetn,
   input wire logic       two_wire_mode,
   input wire logic       host_serial_clk,
   input wire logic       host_chip_select_n,
   input wire logic       host_serial_out,
   input wire logic       host_serial_out_oe,
   input wire logic       rx_valid,
   input wire logic       rx_ready,
   input wire hspi_word_t rx_word,
   input wire logic       tx_ready,
   input wire logic       frame_end,
   input wire logic       frame_error,
   input wire logic       rx_overrun,
   input wire logic       busy
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   // ----------------------------------------------------------
   // pin side
   // ----------------------------------------------------------
   // pin pipe is three edges, release one more
   property p_oe_idle;
      host_chip_select_n [*5] |-> !host_serial_out_oe;
   endproperty
   a_oe_idle: assert property (p_oe_idle) else $error("oe high with cs off");
   property p_oe_start;
      $rose(host_serial_out_oe) |-> !host_chip_select_n && busy;
   endproperty
   a_oe_start: assert property (p_oe_start) else $error("oe rose without cs");
   // shifts land only while the host clock is low
   property p_out_edge;
      $changed(host_serial_out) && $past(host_serial_out_oe) && host_serial_out_oe
         |-> !$past(host_serial_clk);
   endproperty
   a_out_edge: assert property (p_out_edge) else $error("out moved off fall");
   property p_two_wire;
      two_wire_mode [*3] |-> !host_serial_out_oe;
   endproperty
   a_two_wire: assert property (p_two_wire) else $error("oe in two-wire mode");
   property p_oe_busy;
      host_serial_out_oe |-> busy;
   endproperty
   a_oe_busy: assert property (p_oe_busy) else $error("oe while idle");

   // ----------------------------------------------------------
   // user side
   // ----------------------------------------------------------
   property p_end_pulse;
      frame_end |=> !frame_end;
   endproperty
   a_end_pulse: assert property (p_end_pulse) else $error("frame end held");
   property p_err_end;
      frame_error |-> frame_end;
   endproperty
   a_err_end: assert property (p_err_end) else $error("error without end");
   property p_rx_hold;
      rx_valid && !rx_ready |=> rx_valid && $stable(rx_word);
   endproperty
   a_rx_hold: assert property (p_rx_hold) else $error("word lost while stalled");
   property p_tx_pulse;
      tx_ready |=> !tx_ready;
   endproperty
   a_tx_pulse: assert property (p_tx_pulse) else $error("tx ready held");
   c_err: cover property (frame_error);
   c_ovr: cover property (rx_overrun);
   c_oe: cover property ($rose(host_serial_out_oe));
endmodule
bind hspi_slave hspi_slave_checker u_chk (.clk(clk), .resetn(resetn),
   .two_wire_mode(two_wire_mode), .host_serial_clk(host_serial_clk),
   .host_chip_select_n(host_chip_select_n), .host_serial_out(host_serial_out),
   .host_serial_out_oe(host_serial_out_oe), .rx_valid(rx_valid), .rx_ready(rx_ready),
   .rx_word(rx_word), .tx_ready(tx_ready), .frame_end(frame_end),
   .frame_error(frame_error), .rx_overrun(rx_overrun), .busy(busy));
`default_nettype wire

/* File: verilog/hspi_fifo.sv */
// synchronous word fifo with valid/ready on both sides
`timescale 1ns/1ps
`default_nettype none
module hspi_fifo #(
   parameter int WIDTH = 17,
   parameter int DEPTH = 32
) (
   input  wire logic             clk,
   input  wire logic             resetn,
   input  wire logic             in_valid,
   output logic                  in_ready,
   input  wire logic [WIDTH-1:0] in_data,
   output logic                  out_valid,
   input  wire logic             out_ready,
   output logic      [WIDTH-1:0] out_data
);
   localparam int AW = $clog2(DEPTH);

   // ---------------------------------------------------------------
   // storage and pointers
   // ---------------------------------------------------------------
   logic [WIDTH-1:0] mem_q [DEPTH];
   logic [AW:0]      wr_q;
   logic [AW:0]      rd_q;
   logic             push;
   logic             pop;

   // extra pointer bit tells full from empty
   assign in_ready  = (wr_q[AW] == rd_q[AW]) || (wr_q[AW-1:0] != rd_q[AW-1:0]);
   assign out_valid = (wr_q != rd_q);
   assign push      = in_valid && in_ready;
   assign pop       = out_valid && out_ready;
   assign out_data  = mem_q[rd_q[AW-1:0]];

   // write side
   always_ff @(posedge clk) begin
      if (push) begin
         mem_q[wr_q[AW-1:0]] <= in_data;
      end
   end

   // pointer updates
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         wr_q <= '0;
         rd_q <= '0;
      end else begin
         if (push) begin
            wr_q <= wr_q + 1'b1;
         end
         if (pop) begin
            rd_q <= rd_q + 1'b1;
         end
      end
   end
endmodule
`default_nettype wire

/* File: verilog/hspi_pkg.sv */
// shared constants and types for the host serial slave front end
package hspi_pkg;

   // ---------------------------------------------------------------
   // clock and timing
   // ---------------------------------------------------------------
   localparam int HSPI_SYS_CLK_HZ    = 10_000_000;
   localparam int HSPI_SYS_PERIOD_NS = 100;
   localparam int HSPI_SCLK_MAX_HZ   = 25_000_000;  // fastest host serial clock
   localparam int HSPI_CS_OFF_NS     = 61;          // least chip-select off time
   // least time rounds up, never below one cycle
   localparam int HSPI_CS_OFF_RAW    = (HSPI_CS_OFF_NS + HSPI_SYS_PERIOD_NS - 1)
                                       / HSPI_SYS_PERIOD_NS;
   localparam int HSPI_CS_OFF_CYC    = (HSPI_CS_OFF_RAW < 1) ? 1 : HSPI_CS_OFF_RAW;

   // ---------------------------------------------------------------
   // word geometry
   // ---------------------------------------------------------------
   localparam int HSPI_WORD_BITS  = 16;
   localparam int HSPI_BYTE_BITS  = 8;
   localparam int HSPI_FIFO_DEPTH = 32;
   localparam int HSPI_CNT_W      = 5;
   localparam logic [HSPI_CNT_W-1:0] HSPI_CNT_RST   = 5'h00;
   localparam logic [HSPI_CNT_W-1:0] HSPI_LAST_BYTE = 5'h07;
   localparam logic [HSPI_CNT_W-1:0] HSPI_LAST_WORD = 5'h0f;
   localparam logic [HSPI_CNT_W-1:0] HSPI_OFF_LAST  =
      HSPI_CNT_W'(HSPI_CS_OFF_CYC - 1);
   localparam logic [15:0] HSPI_SH_RST = 16'h0000;

   // pin vector positions inside the synchroniser
   localparam int HSPI_PIN_SCLK = 0;
   localparam int HSPI_PIN_CSN  = 1;
   localparam int HSPI_PIN_SDI  = 2;
   localparam int HSPI_PIN_N    = 3;
   localparam logic [2:0] HSPI_PIN_RST = 3'h3;  // clock high, chip select off

   // ---------------------------------------------------------------
   // modes and states
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      HSPI_FRAME_BYTE = 2'h0,
      HSPI_FRAME_WORD = 2'h1,
      HSPI_FRAME_CMD  = 2'h2
   } hspi_frame_t;

   typedef enum logic [2:0] {
      HSPI_ST_IDLE    = 3'h1,
      HSPI_ST_ACTIVE  = 3'h2,
      HSPI_ST_RECOVER = 3'h4
   } hspi_state_t;

   // one received word toward the command interpreter
   typedef struct packed {
      logic        first;   // first word after chip select fell
      logic [15:0] data;    // byte mode: data in the low eight bits
   } hspi_word_t;

   localparam int HSPI_RXW_W = $bits(hspi_word_t);

endpackage

/* File: verilog/hspi_slave.sv */
// host bus port serial slave: pin sampling, word framing, serial output, rx fifo
//
// Behaviour
// (R1) The port gives the outside host read and write reach to all memory and registers.
// (R2) The port is either a serial peripheral slave or a two-wire slave; this is the former.
// (R3) The slave works with a host serial clock of up to 25 MHz; here each host clock level must last two clk periods.
// (R4) The host clock may stop high or low for any time without loss of data.
// (R5) While chip select is low each 16 received bits go out as one 16-bit word; byte framing here closes a word every 8 bits, zero-extended.
// (R6) The first output bit is driven on the later of chip-select fall and clock fall.
// (R7) The host keeps chip select high at least 61 ns between low periods.
// (R8) In command framing chip select stays low over all words of one command.
// (R9) The slave resets when a low period is not a whole number of 8 or 16 clocks.
// (R10) In byte or word framing one low period may carry several whole commands.
// (R11) The chip-select rising edge ends the sequence and resets the interface logic.
// (R12) A host sampling on the rising edge allows the output delay plus its own setup.
// (R13) The serial output is driven only while chip select is low, else released; here oe lags chip select by the synchroniser.
// (R14) Input is sampled on the rising clock edge and output changes on the falling edge.
// (R15) The two-wire mode shares these same pins instead of pins of its own.
`timescale 1ns/1ps
`default_nettype none
module hspi_slave
   import hspi_pkg::*;
(
   input  wire logic        clk,
   input  wire logic        resetn,
   // configuration straps
   input  wire logic        two_wire_mode,      // port set up as two-wire slave
   input  wire hspi_frame_t frame_mode,
   // host pins
   input  wire logic        host_serial_clk,
   input  wire logic        host_chip_select_n,
   input  wire logic        host_serial_in,
   output logic             host_serial_out,
   output logic             host_serial_out_oe,
   // received words toward the command interpreter
   output logic             rx_valid,
   input  wire logic        rx_ready,
   output var hspi_word_t   rx_word,
   // words to send back to the host
   input  wire logic        tx_valid,
   output logic             tx_ready,
   input  wire logic [15:0] tx_data,
   // status pulses and busy level
   output logic             frame_end,
   output logic             frame_error,
   output logic             rx_overrun,
   output logic             busy
);

   // ---------------------------------------------------------------
   // pin synchroniser
   // ---------------------------------------------------------------
   logic [HSPI_PIN_N-1:0] pin_raw;
   logic [HSPI_PIN_N-1:0] pin_s1_q;
   logic [HSPI_PIN_N-1:0] pin_s2_q;
   logic [HSPI_PIN_N-1:0] pin_s3_q;     // delayed copy for edge detection

   assign pin_raw[HSPI_PIN_SCLK] = host_serial_clk;
   assign pin_raw[HSPI_PIN_CSN]  = host_chip_select_n;
   assign pin_raw[HSPI_PIN_SDI]  = host_serial_in;

   // two flops before anything looks at the pins; the host clock is asynchronous
   // limitation: each host clock level must last two clk periods, so 25 MHz needs a faster clk
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         pin_s1_q <= HSPI_PIN_RST;
         pin_s2_q <= HSPI_PIN_RST;
         pin_s3_q <= HSPI_PIN_RST;
      end else begin
         pin_s1_q <= pin_raw;
         pin_s2_q <= pin_s1_q;  // [R3]
         pin_s3_q <= pin_s2_q;
      end
   end

   // ---------------------------------------------------------------
   // edge events
   // ---------------------------------------------------------------
   logic sclk_rise;
   logic sclk_fall;
   logic cs_fall;
   logic cs_rise;
   logic sdi_bit;

   // edges only exist when the host clock moves, so a stopped clock loses nothing
   assign sclk_rise = pin_s2_q[HSPI_PIN_SCLK] && !pin_s3_q[HSPI_PIN_SCLK];  // [R4] [R14]
   assign sclk_fall = !pin_s2_q[HSPI_PIN_SCLK] && pin_s3_q[HSPI_PIN_SCLK];  // [R14]
   assign cs_fall   = !pin_s2_q[HSPI_PIN_CSN] && pin_s3_q[HSPI_PIN_CSN];
   assign cs_rise   = pin_s2_q[HSPI_PIN_CSN] && !pin_s3_q[HSPI_PIN_CSN];
   assign sdi_bit   = pin_s2_q[HSPI_PIN_SDI];  // same latency as the clock edge

   // ---------------------------------------------------------------
   // framing state machine
   // ---------------------------------------------------------------
   hspi_state_t           state_q;
   hspi_state_t           state_d;
   logic [HSPI_CNT_W-1:0] off_cnt_q;
   logic                  start_ev;
   logic                  active;

   // the two-wire mode owns the shared pins, so this slave stays idle then
   assign start_ev = (state_q == HSPI_ST_IDLE) && cs_fall && !two_wire_mode;  // [R2] [R15]
   assign active   = (state_q == HSPI_ST_ACTIVE);

   // next state
   always_comb begin
      state_d = state_q;
      case (state_q)
         HSPI_ST_IDLE: begin
            if (start_ev) begin
               state_d = HSPI_ST_ACTIVE;
            end
         end
         HSPI_ST_ACTIVE: begin
            if (cs_rise || two_wire_mode) begin
               state_d = HSPI_ST_RECOVER;  // [R11]
            end
         end
         HSPI_ST_RECOVER: begin
            // a fall inside the off time is not taken as a new period
            if (off_cnt_q >= HSPI_OFF_LAST) begin
               state_d = HSPI_ST_IDLE;  // [R7]
            end
         end
         default: begin
            state_d = HSPI_ST_IDLE;
         end
      endcase
   end

   // state register
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         state_q <= HSPI_ST_IDLE;
      end else begin
         state_q <= state_d;
      end
   end

   // chip-select off time counter
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         off_cnt_q <= HSPI_CNT_RST;
      end else if (state_q != HSPI_ST_RECOVER) begin
         off_cnt_q <= HSPI_CNT_RST;
      end else if (off_cnt_q != HSPI_OFF_LAST) begin
         off_cnt_q <= off_cnt_q + 1'b1;
      end
   end

   // ---------------------------------------------------------------
   // receive shift and word assembly
   // ---------------------------------------------------------------
   logic [HSPI_CNT_W-1:0] bit_cnt_q;
   logic [15:0]           rx_sh_q;
   logic                  first_q;
   logic [HSPI_CNT_W-1:0] last_bit;
   logic                  word_done;
   hspi_word_t            push_word_q;
   logic                  push_q;
   logic                  fifo_in_ready;

   // byte framing closes a unit after 8 clocks, word and command after 16
   assign last_bit  = (frame_mode == HSPI_FRAME_BYTE) ? HSPI_LAST_BYTE : HSPI_LAST_WORD;
   assign word_done = active && sclk_rise && (bit_cnt_q == last_bit);  // [R5]

   // bit counter restarts at every word and at every new low period
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         bit_cnt_q <= HSPI_CNT_RST;
      end else if (!active || word_done) begin
         bit_cnt_q <= HSPI_CNT_RST;  // [R11] [R10]
      end else if (sclk_rise) begin
         bit_cnt_q <= bit_cnt_q + 1'b1;
      end
   end

   // serial input shifts in msb first on the sampling edge
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         rx_sh_q <= HSPI_SH_RST;
      end else if (start_ev) begin
         rx_sh_q <= HSPI_SH_RST;
      end else if (active && sclk_rise) begin
         rx_sh_q <= {rx_sh_q[14:0], sdi_bit};  // [R14]
      end
   end

   // first-word marker so the interpreter can find the command head
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         first_q <= 1'b0;
      end else if (start_ev) begin
         first_q <= 1'b1;  // [R8]
      end else if (word_done) begin
         first_q <= 1'b0;
      end
   end

   // completed word handed on one cycle later
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         push_q      <= 1'b0;
         push_word_q <= '0;
      end else begin
         push_q <= word_done;
         if (word_done) begin
            push_word_q.first <= first_q;
            if (frame_mode == HSPI_FRAME_BYTE) begin
               push_word_q.data <= {8'h00, rx_sh_q[6:0], sdi_bit};
            end else begin
               push_word_q.data <= {rx_sh_q[14:0], sdi_bit};  // [R5]
            end
         end
      end
   end

   // ---------------------------------------------------------------
   // receive fifo toward the command interpreter
   // ---------------------------------------------------------------
   // the host cannot be stalled, so a full fifo drops the word and says so
   hspi_fifo #(
      .WIDTH (HSPI_RXW_W),
      .DEPTH (HSPI_FIFO_DEPTH)
   ) u_rx_fifo (
      .clk       (clk),
      .resetn    (resetn),
      .in_valid  (push_q),
      .in_ready  (fifo_in_ready),
      .in_data   (push_word_q),
      .out_valid (rx_valid),
      .out_ready (rx_ready),
      .out_data  (rx_word)
   );  // [R1]

   // ---------------------------------------------------------------
   // transmit shift
   // ---------------------------------------------------------------
   logic [15:0] tx_sh_q;
   logic        rose_q;      // a sampling edge seen since the last load or shift
   logic        reload_ev;
   logic        load_ev;
   logic [15:0] load_val;

   // next word loads at the driving edge after a word closed
   assign reload_ev = active && sclk_fall && rose_q && (bit_cnt_q == HSPI_CNT_RST);
   assign load_ev   = start_ev || reload_ev;
   assign tx_ready  = load_ev;

   // no word offered means zeros; byte framing sends the low byte
   always_comb begin
      load_val = HSPI_SH_RST;
      if (tx_valid) begin
         if (frame_mode == HSPI_FRAME_BYTE) begin
            load_val = {tx_data[7:0], 8'h00};
         end else begin
            load_val = tx_data;
         end
      end
   end

   // first bit appears at chip-select fall and holds through a leading
   // clock fall, since no sampling edge has come yet
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         tx_sh_q <= HSPI_SH_RST;
         rose_q  <= 1'b0;
      end else if (load_ev) begin
         tx_sh_q <= load_val;  // [R6]
         rose_q  <= 1'b0;
      end else if (active && sclk_rise) begin
         rose_q <= 1'b1;
      end else if (active && sclk_fall && rose_q) begin
         tx_sh_q <= {tx_sh_q[14:0], 1'b0};  // [R14]
         rose_q  <= 1'b0;
      end
   end

   // output pin straight from the shift register
   assign host_serial_out    = tx_sh_q[15];
   assign host_serial_out_oe = active;  // [R13] [R6]

   // ---------------------------------------------------------------
   // status pulses and busy level
   // ---------------------------------------------------------------
   logic end_q;
   logic err_q;
   logic ovr_q;

   // a partial word at chip-select rise is discarded and flagged
   always_ff @(posedge clk or negedge resetn) begin
      if (!resetn) begin
         end_q <= 1'b0;
         err_q <= 1'b0;
         ovr_q <= 1'b0;
      end else begin
         end_q <= active && cs_rise;  // [R11]
         err_q <= active && cs_rise && (bit_cnt_q != HSPI_CNT_RST);  // [R9]
         ovr_q <= push_q && !fifo_in_ready;
      end
   end

   assign frame_end   = end_q;
   assign frame_error = err_q;
   assign rx_overrun  = ovr_q;
   assign busy        = (state_q != HSPI_ST_IDLE);

endmodule
`default_nettype wire
